/* File: core/stack_op_exec.sv */
// Executor for the indexed move, literal push and pointer subtracts
//
// Notes on behaviour
// (RULE1) The indexed move copies the source byte to the destination over two words and two cycles, reading in the first and writing in the second.
// (RULE2) Source and destination addresses are the frame pointer plus each word's 7-bit unsigned offset.
// (RULE3) Those addresses may land anywhere in the 4096-byte data space, wrapping at the top.
// (RULE4) Software never aims the move at the program counter low byte or a return-stack-top byte.
// (RULE5) A source address on an indirect-access register reads as zero.
// (RULE6) A destination address on an indirect-access register suppresses the write.
// (RULE7) The literal push writes its 8-bit literal at the frame pointer address in one cycle.
// (RULE8) After that store the push lowers the frame pointer by exactly one.
// (RULE9) The pointer subtract takes the 6-bit literal from pointer 0 to 2 and writes it back, flags untouched.
// (RULE10) Select value 3 decodes as the subtract-and-return form, which always acts on the frame pointer.
// (RULE11) Subtract-and-return takes two cycles: work in the first, a no-operation in the second.
// (RULE12) Subtract-and-return loads the program counter from the return-stack top and pops it.
// (RULE13) These instructions run only when the extended-set enable is set; it resets to off.
`timescale 1ns/100ps
module stack_op_exec
   import stackop_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Configuration
   input wire logic extended_set_enable,
   // Instruction stream from the decoder
   input wire logic [1:0] q_phase,
   input wire logic instr_valid,
   input wire logic [stackop_pkg::WORD_W-1:0] instr_word,
   output logic ext_claim,
   output logic retire_flush,
   // Data memory port
   output logic [stackop_pkg::ADDR_W-1:0] dmem_addr,
   output logic dmem_rd,
   input wire logic [7:0] dmem_rdata,
   output logic dmem_wr,
   output logic [7:0] dmem_wdata,
   // Return stack and program counter
   input wire logic [stackop_pkg::PC_W-1:0] return_stack_top,
   output logic stack_pop,
   output logic pc_load,
   output logic [stackop_pkg::PC_W-1:0] pc_load_value,
   // Pointer view
   output logic [stackop_pkg::ADDR_W-1:0] frame_pointer,
   output logic [stackop_pkg::ADDR_W-1:0] pointer0,
   output logic [stackop_pkg::ADDR_W-1:0] pointer1
);
   import stackop_pkg::*;

   logic ext_en_q;
   state_t state_q;
   op_t op_q;
   logic [7:0] lit_q;
   logic [1:0] sel_q;
   logic [7:0] rbyte_q;
   logic dst_ind_q;
   logic take;
   logic hit_move1;
   logic hit_move2;
   logic hit_push;
   logic hit_psub;
   logic q3_act;
   logic [11:0] sel_ptr;
   logic [11:0] dst_addr;
   logic ptr_we;
   logic [1:0] ptr_wsel;
   logic [11:0] ptr_wval;
   logic [11:0] addr_q;
   logic rd_q;
   logic wr_q;
   logic [7:0] wdata_q;
   logic pop_q;
   logic pcl_q;
   logic [20:0] pcv_q;
   logic flush_q;

   // Enable bit taken after reset release; off until then
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) ext_en_q <= EXT_EN_RST; // RULE13
      else ext_en_q <= extended_set_enable; // RULE13
   end

   // Decode of a first or second word at Q1
   assign take = instr_valid && (q_phase == PH_Q1) && ext_en_q; // RULE13
   assign hit_move1 = op_hit(instr_word, OPC_MOVE1, MSK_MOVE1);
   assign hit_move2 = op_hit(instr_word, OPC_MOVE2, MSK_MOVE2);
   assign hit_push = op_hit(instr_word, OPC_PUSH, MSK_PUSH);
   assign hit_psub = op_hit(instr_word, OPC_PSUB, MSK_PSUB);

   // Claim tells the core that this block owns the current word; the
   // second move word is ours too, while the dead cycle after a return
   // is left unclaimed and covered by retire_flush instead
   always_comb begin
      ext_claim = 1'b0;
      if (take) begin
         if (state_q == ST_MOVE2) ext_claim = hit_move2;
         else if (state_q == ST_IDLE)
            ext_claim = hit_move1 || hit_push || hit_psub;
      end
   end

   // Operation capture at Q1
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         op_q <= OP_NONE;
         lit_q <= 8'h00;
         sel_q <= 2'h0;
      end else if (q_phase == PH_Q1) begin
         op_q <= OP_NONE;
         if (take && state_q == ST_IDLE) begin
            lit_q <= instr_word[LIT_MSB:0];
            sel_q <= instr_word[SEL_MSB:SEL_LSB];
            if (hit_move1) op_q <= OP_MOVE;
            else if (hit_push) op_q <= OP_PUSH;
            else if (hit_psub &&
                     instr_word[SEL_MSB:SEL_LSB] == SEL_RETURN)
               op_q <= OP_SRET; // RULE10
            else if (hit_psub) op_q <= OP_PSUB;
         end else if (take && state_q == ST_MOVE2 && hit_move2) begin
            lit_q <= instr_word[LIT_MSB:0];
            op_q <= OP_MOVE;
         end
      end
   end

   // Sequencer across instruction cycles; a missing second move word
   // drops the move rather than stalling the core
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else if (q_phase == PH_Q1) begin
         unique case (state_q)
            ST_IDLE: begin
               if (take && hit_move1) state_q <= ST_MOVE2; // RULE1
               else if (take && hit_psub &&
                        instr_word[SEL_MSB:SEL_LSB] == SEL_RETURN)
                  state_q <= ST_RETNOP; // RULE11
            end
            ST_MOVE2: begin
               state_q <= ST_IDLE;
            end
            ST_RETNOP: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Actions are issued at the Q3 edge so strobes stand during Q4
   assign q3_act = (q_phase == PH_Q3);
   assign sel_ptr = (sel_q == 2'h0) ? pointer0 :
                    (sel_q == 2'h1) ? pointer1 : frame_pointer;
   assign dst_addr = offset_addr(frame_pointer, lit_q[OFS_MSB:OFS_LSB]);

   // Pointer updates: push steps down, subtracts take the 6-bit literal
   always_comb begin
      ptr_we = 1'b0;
      ptr_wsel = SEL_FRAME;
      ptr_wval = frame_pointer;
      if (q3_act && op_q == OP_PUSH) begin
         ptr_we = 1'b1;
         ptr_wval = frame_pointer - FP_STEP; // RULE8
      end else if (q3_act && op_q == OP_PSUB) begin
         ptr_we = 1'b1;
         ptr_wsel = sel_q;
         ptr_wval = sel_ptr - {6'h00, lit_q[K6_MSB:0]}; // RULE9
      end else if (q3_act && op_q == OP_SRET) begin
         ptr_we = 1'b1;
         ptr_wval = frame_pointer - {6'h00, lit_q[K6_MSB:0]}; // RULE10
      end
   end

   pointer_bank u_ptrs (
      .mclk(mclk),
      .rst(rst),
      .wr_en(ptr_we),
      .wr_sel(ptr_wsel),
      .wr_val(ptr_wval),
      .ptr0(pointer0),
      .ptr1(pointer1),
      .ptr2(frame_pointer)
   );

   // Data memory strobes; one quarter long each
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_q <= 12'h000;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 8'h00;
         dst_ind_q <= 1'b0;
      end else begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         if (q3_act && op_q == OP_MOVE && state_q == ST_MOVE2) begin
            addr_q <= dst_addr; // RULE2 RULE3
            rd_q <= 1'b1; // RULE1
            dst_ind_q <= 1'b0;
         end else if (q3_act && op_q == OP_MOVE) begin
            addr_q <= dst_addr; // RULE2
            wdata_q <= rbyte_q; // RULE1
            wr_q <= !is_indirect(dst_addr); // RULE6
            dst_ind_q <= is_indirect(dst_addr);
         end else if (q3_act && op_q == OP_PUSH) begin
            addr_q <= frame_pointer; // RULE7
            wdata_q <= lit_q; // RULE7
            wr_q <= 1'b1;
         end
      end
   end

   // Source byte caught while the read strobe stands; an indirect
   // source reads as zero without trusting the memory answer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rbyte_q <= 8'h00;
      else if (rd_q && is_indirect(addr_q)) rbyte_q <= IND_READ_VAL; // RULE5
      else if (rd_q) rbyte_q <= dmem_rdata;
   end

   // Return: program counter from stack top, entry popped, then a
   // flushed cycle while the target instruction is fetched
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pop_q <= 1'b0;
         pcl_q <= 1'b0;
         pcv_q <= 21'h00_0000;
         flush_q <= 1'b0;
      end else begin
         pop_q <= q3_act && op_q == OP_SRET; // RULE12
         pcl_q <= q3_act && op_q == OP_SRET; // RULE12
         // Set wins over the clear if both fall on one edge
         if (q3_act && op_q == OP_SRET) begin
            pcv_q <= return_stack_top; // RULE12
            flush_q <= 1'b1; // RULE11
         end else if (q_phase == PH_Q4 && state_q == ST_IDLE) begin
            flush_q <= 1'b0;
         end
      end
   end

   assign dmem_addr = addr_q;
   assign dmem_rd = rd_q;
   assign dmem_wr = wr_q;
   assign dmem_wdata = wdata_q;
   assign stack_pop = pop_q;
   assign pc_load = pcl_q;
   assign pc_load_value = pcv_q;
   assign retire_flush = flush_q;

   // Checks
   logic st_move;
   logic st_push;
   logic st_psub;
   logic st_sret;
   assign st_move = take && state_q == ST_IDLE && hit_move1;
   assign st_push = take && state_q == ST_IDLE && hit_push;
   assign st_psub = take && state_q == ST_IDLE && hit_psub &&
                    instr_word[SEL_MSB:SEL_LSB] != SEL_RETURN;
   assign st_sret = take && state_q == ST_IDLE && hit_psub &&
                    instr_word[SEL_MSB:SEL_LSB] == SEL_RETURN;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_move_read_write: assert property ( // RULE1
      st_move ##4 (instr_valid && hit_move2) |->
      ##3 (dmem_wr || dst_ind_q))
      else $error("move second cycle wrote nothing");
   a_move_read_first: assert property ( // RULE1
      st_move |-> ##3 dmem_rd)
      else $error("move did not read in first cycle");
   a_move_src_addr: assert property ( // RULE2
      st_move |-> ##3 (dmem_addr ==
      offset_addr($past(frame_pointer, 3), $past(instr_word[6:0], 3))))
      else $error("move source address wrong");
   a_move_data_copy: assert property ( // RULE1
      dmem_rd && !is_indirect(dmem_addr) ##4 dmem_wr |->
      dmem_wdata == $past(dmem_rdata, 4))
      else $error("move wrote a byte other than the one read");
   a_src_ind_zero: assert property ( // RULE5
      dmem_rd && is_indirect(dmem_addr) ##4 dmem_wr |->
      dmem_wdata == IND_READ_VAL)
      else $error("indirect source did not read zero");
   // A push may legally land in the indirect window, so only move
   // writes are held to it
   a_dst_ind_nop: assert property ( // RULE6
      dmem_wr && op_q == OP_MOVE |-> !is_indirect(dmem_addr))
      else $error("write reached an indirect register");
   a_push_store: assert property ( // RULE7
      st_push |-> ##3 (dmem_wr && dmem_addr == $past(frame_pointer, 3)
      && dmem_wdata == $past(instr_word[7:0], 3)))
      else $error("push stored wrong byte or address");
   a_push_step: assert property ( // RULE8
      st_push |-> ##3 frame_pointer == $past(frame_pointer, 3) - FP_STEP)
      else $error("push did not lower the frame pointer by one");
   a_psub_ptr0: assert property ( // RULE9
      st_psub && instr_word[7:6] == 2'h0 |->
      ##3 pointer0 == $past(pointer0, 3) - {6'h00, $past(instr_word[5:0], 3)})
      else $error("pointer subtract wrong");
   a_sret_frame: assert property ( // RULE10
      st_sret |-> ##3 frame_pointer ==
      $past(frame_pointer, 3) - {6'h00, $past(instr_word[5:0], 3)})
      else $error("return subtract did not hit frame pointer");
   a_sret_nop: assert property ( // RULE11
      st_sret |-> ##4 (retire_flush && !dmem_wr && !dmem_rd)[*4])
      else $error("return second cycle not a no-op");
   a_sret_pop: assert property ( // RULE12
      st_sret |-> ##3 (pc_load && stack_pop &&
      pc_load_value == $past(return_stack_top, 1)))
      else $error("return did not load and pop");
   a_ext_gate: assert property ( // RULE13
      !ext_en_q |-> !ext_claim && !dmem_wr ##4 !dmem_wr)
      else $error("extended op ran while disabled");

   c_move: cover property (st_move ##7 dmem_wr);
   c_push: cover property (st_push ##3 dmem_wr);
   c_sret: cover property (st_sret ##3 pc_load);
   c_dst_ind: cover property (dst_ind_q);

endmodule

/* File: core/stackop_pkg.sv */
// Constants, types and helpers for the stack-frame instruction executor
package stackop_pkg;

   // Widths
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned PC_W = 21;
   localparam int unsigned WORD_W = 16;

   // Opcode patterns and masks
   localparam logic [15:0] OPC_MOVE1 = 16'hEB80;
   localparam logic [15:0] MSK_MOVE1 = 16'hFF80;
   localparam logic [15:0] OPC_MOVE2 = 16'hF000;
   localparam logic [15:0] MSK_MOVE2 = 16'hF000;
   localparam logic [15:0] OPC_PUSH = 16'hFA00;
   localparam logic [15:0] MSK_PUSH = 16'hFF00;
   localparam logic [15:0] OPC_PSUB = 16'hE900;
   localparam logic [15:0] MSK_PSUB = 16'hFF00;

   // Field positions
   localparam int unsigned OFS_LSB = 0;
   localparam int unsigned OFS_MSB = 6;
   localparam int unsigned LIT_MSB = 7;
   localparam int unsigned K6_MSB = 5;
   localparam int unsigned SEL_LSB = 6;
   localparam int unsigned SEL_MSB = 7;

   // Pointer selects
   localparam logic [1:0] SEL_FRAME = 2'h2;
   localparam logic [1:0] SEL_RETURN = 2'h3;

   // Indirect-access register window of the data space
   localparam logic [11:0] IND_REG_LO = 12'hFEB;
   localparam logic [11:0] IND_REG_HI = 12'hFEF;

   // Value read back from an indirect register
   localparam logic [7:0] IND_READ_VAL = 8'h00;

   // Quarter phase codes
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // Reset values and the frame pointer step
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic EXT_EN_RST = 1'b0;
   localparam logic [11:0] FP_STEP = 12'h001;

   // Operation being executed
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_MOVE = 3'b001,
      OP_PUSH = 3'b010,
      OP_PSUB = 3'b011,
      OP_SRET = 3'b100
   } op_t;

   // Instruction-cycle sequencing
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MOVE2 = 2'b01,
      ST_RETNOP = 2'b10
   } state_t;

   // Frame pointer plus 7-bit unsigned offset, wrapping in 4 KiB
   function automatic logic [11:0] offset_addr(input logic [11:0] base,
                                               input logic [6:0] ofs);
      offset_addr = base + {5'h00, ofs};
   endfunction

   // True for the indirect-access registers
   function automatic logic is_indirect(input logic [11:0] a);
      is_indirect = (a >= IND_REG_LO) && (a <= IND_REG_HI);
   endfunction

   // Opcode match under mask
   function automatic logic op_hit(input logic [15:0] w,
                                   input logic [15:0] opc,
                                   input logic [15:0] msk);
      op_hit = (w & msk) == opc;
   endfunction

endpackage

/* File: core/pointer_bank.sv */
// Three 12-bit file-select pointer registers with one write port
`timescale 1ns/100ps
module pointer_bank
   import stackop_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Write port
   input wire logic wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [stackop_pkg::ADDR_W-1:0] wr_val,
   // Register contents
   output logic [stackop_pkg::ADDR_W-1:0] ptr0,
   output logic [stackop_pkg::ADDR_W-1:0] ptr1,
   output logic [stackop_pkg::ADDR_W-1:0] ptr2
);

   // Select 3 has no register of its own; it is mapped to the frame
   // pointer by the caller, so it is ignored here
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ptr0 <= PTR_RST;
         ptr1 <= PTR_RST;
         ptr2 <= PTR_RST;
      end else if (wr_en) begin
         if (wr_sel == 2'h0) ptr0 <= wr_val;
         if (wr_sel == 2'h1) ptr1 <= wr_val;
         if (wr_sel == SEL_FRAME) ptr2 <= wr_val;
      end
   end

endmodule

/* File: verif/stack_op_exec_tb.sv */
// Self-checking bench for the stack-frame instruction executor
`timescale 1ns/100ps
module stack_op_exec_tb;
   import stackop_pkg::*;

   logic mclk, rst, extended_set_enable, instr_valid;
   logic [1:0] q_phase;
   logic [15:0] instr_word;
   logic ext_claim, retire_flush, dmem_rd, dmem_wr, stack_pop, pc_load;
   logic [11:0] dmem_addr, frame_pointer, pointer0, pointer1;
   logic [7:0] dmem_rdata, dmem_wdata;
   logic [20:0] return_stack_top, pc_load_value;
   logic [7:0] mem [0:4095];
   logic en_g;
   logic [20:0] stk_g;
   logic claim_s, rd_s, wr_s, pop_s, pcl_s, fl_s;
   logic [11:0] addr_s;
   logic [7:0] wdata_s;
   logic [20:0] pcv_s;
   int fail_count, checks;

   stack_op_exec dut (
      .mclk(mclk), .rst(rst), .extended_set_enable(extended_set_enable),
      .q_phase(q_phase), .instr_valid(instr_valid),
      .instr_word(instr_word), .ext_claim(ext_claim),
      .retire_flush(retire_flush), .dmem_addr(dmem_addr),
      .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr),
      .dmem_wdata(dmem_wdata), .return_stack_top(return_stack_top),
      .stack_pop(stack_pop), .pc_load(pc_load),
      .pc_load_value(pc_load_value), .frame_pointer(frame_pointer),
      .pointer0(pointer0), .pointer1(pointer1)
   );

   // Free-running core clock, 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Quarter phases parked at Q4 in reset so Q1 follows the release
   always @(posedge mclk) begin
      q_phase <= rst ? 2'h3 : q_phase + 2'h1;
   end

   // Data memory: reads answer within the strobe, junk otherwise
   always @(posedge mclk) begin
      if (dmem_wr === 1'b1) mem[dmem_addr] <= dmem_wdata;
   end
   assign dmem_rdata = (dmem_rd === 1'b1) ? mem[dmem_addr] : ~mem[dmem_addr];

   // Known contents so a copied byte can be told from a stale one
   function automatic logic [7:0] init_byte(input logic [11:0] a);
      init_byte = a[7:0] ^ 8'hA5;
   endfunction

   task chk(input logic [20:0] got, input logic [20:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // One instruction cycle: entered in Q4, returns sampled in next Q4
   task slot(input logic [15:0] w, input logic v);
      @(posedge mclk);
      instr_word <= w;
      instr_valid <= v;
      extended_set_enable <= en_g;
      return_stack_top <= stk_g;
      #1 claim_s = ext_claim;
      @(posedge mclk);
      instr_valid <= 1'b0;
      instr_word <= ~w;
      repeat (2) @(posedge mclk);
      #1;
      rd_s = dmem_rd;
      wr_s = dmem_wr;
      addr_s = dmem_addr;
      wdata_s = dmem_wdata;
      pop_s = stack_pop;
      pcl_s = pc_load;
      pcv_s = pc_load_value;
      fl_s = retire_flush;
   endtask

   // Extended set off after reset: a push is ignored
   task t_disabled;
      chk(frame_pointer, 12'h000);
      slot(OPC_PUSH | 16'h0042, 1'b1);
      chk(claim_s, 1'b0);
      chk(wr_s, 1'b0);
      chk(frame_pointer, 12'h000);
      en_g = 1'b1;
      slot(16'h0000, 1'b0);
      $display("test disabled done");
   endtask

   // Each pointer select once, wrapping below zero
   task t_sub;
      logic [5:0] ks [3];
      ks = '{6'h3F, 6'h01, 6'h20};
      for (int s = 0; s < 3; s++) begin
         slot(OPC_PSUB | (16'(s) << 6) | 16'(ks[s]), 1'b1);
         chk(claim_s, 1'b1);
      end
      chk(pointer0, 12'hFC1);
      chk(pointer1, 12'hFFF);
      chk(frame_pointer, 12'hFE0);
      $display("test subtract done");
   endtask

   // Two pushes back to back
   task t_push;
      slot(OPC_PUSH | 16'h00FF, 1'b1);
      chk(wr_s, 1'b1);
      chk(addr_s, 12'hFE0);
      chk(wdata_s, 8'hFF);
      chk(frame_pointer, 12'hFDF);
      slot(OPC_PUSH | 16'h003C, 1'b1);
      chk(addr_s, 12'hFDF);
      chk(wdata_s, 8'h3C);
      chk(frame_pointer, 12'hFDE);
      chk(mem[12'hFE0], 8'hFF);
      $display("test push done");
   endtask

   // Largest offset carries the source past the top of the space
   task t_move;
      slot(OPC_MOVE1 | 16'h007F, 1'b1);
      chk(rd_s, 1'b1);
      chk(wr_s, 1'b0);
      chk(addr_s, 12'h05D);
      // Destination is ordinary data, never a program counter or stack byte
      slot(16'hF380, 1'b1);
      chk(wr_s, 1'b1);
      chk(addr_s, 12'hFDE);
      chk(wdata_s, init_byte(12'h05D));
      chk(frame_pointer, 12'hFDE);
      // A first word with no second move word behind it is dropped
      slot(OPC_MOVE1 | 16'h0005, 1'b1);
      slot(16'h0000, 1'b1);
      chk(claim_s, 1'b0);
      chk(wr_s, 1'b0);
      chk(rd_s, 1'b0);
      $display("test move done");
   endtask

   // Indirect registers as source, then as destination
   task t_indirect;
      slot(OPC_MOVE1 | 16'h000D, 1'b1);
      slot(OPC_MOVE2 | 16'h0001, 1'b1);
      chk(wr_s, 1'b1);
      chk(addr_s, 12'hFDF);
      chk(wdata_s, 8'h00);
      slot(OPC_MOVE1, 1'b1);
      slot(OPC_MOVE2 | 16'h0011, 1'b1);
      chk(wr_s, 1'b0);
      $display("test indirect done");
   endtask

   // Subtract-and-return, then its dead second cycle
   task t_sret;
      stk_g = 21'h1A_BCDE;
      slot(16'hE9DE, 1'b1);
      chk(claim_s, 1'b1);
      chk(frame_pointer, 12'hFC0);
      chk(pointer0, 12'hFC1);
      chk(pointer1, 12'hFFF);
      chk(pcl_s, 1'b1);
      chk(pop_s, 1'b1);
      chk(pcv_s, 21'h1A_BCDE);
      chk(fl_s, 1'b1);
      stk_g = 21'h05_0505;
      slot(OPC_PUSH | 16'h0077, 1'b1);
      chk(wr_s, 1'b0);
      chk(pop_s, 1'b0);
      chk(pcl_s, 1'b0);
      chk(frame_pointer, 12'hFC0);
      slot(16'h0000, 1'b0);
      chk(fl_s, 1'b0);
      $display("test return done");
   endtask

   // Main sequence
   initial begin
      fail_count = 0;
      checks = 0;
      rst = 1'b1;
      q_phase = 2'h3;
      en_g = 1'b0;
      stk_g = 21'h00_0000;
      extended_set_enable = 1'b0;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      return_stack_top = 21'h00_0000;
      for (int i = 0; i < 4096; i++) mem[i] = init_byte(12'(i));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_disabled();
      t_sub();
      t_push();
      t_move();
      t_indirect();
      t_sret();
      finish_test();
   end

   // Watchdog, far beyond the roughly 80 cycles the tests need
   initial begin
      repeat (2000) @(posedge mclk);
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      finish_test();
   end
endmodule
